// *** hdl/cosr_chdiv.sv ***
// one channel divider with coarse start delay and static hold
// assumes hold and pd are synchronous to clk
`default_nettype none

module cosr_chdiv
  import cosr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic pd,
  input wire logic initial_level_high,
  input wire logic [cosr_pkg::FIELD_W-1:0] delay_count,
  input wire logic [cosr_pkg::FIELD_W-1:0] low_field,
  input wire logic [cosr_pkg::FIELD_W-1:0] high_field,
  output logic level
);

  // divider state
  typedef struct packed {
    logic run; // counting out high and low phases
    logic level; // divider output
    logic [DLY_W-1:0] cnt; // start delay or phase countdown
  } cosr_div_state_t;

  cosr_div_state_t s;
  cosr_div_state_t n;

  // start delay from the combined phase value
  function automatic logic [DLY_W-1:0] start_delay(
    input logic sh,
    input logic [FIELD_W-1:0] po,
    input logic [FIELD_W-1:0] mf
  );
    logic [DLY_W-1:0] phi;
    phi = {1'h0, sh, po};
    if (phi <= 6'h0F) begin
      start_delay = phi;
    end else begin
      // low-cycle count is field plus one, then one more cycle
      start_delay = phi - 6'h10 + {2'h0, mf} + 6'h02;
    end
  endfunction

  // next-state logic
  always_comb begin
    n = s;
    if (pd) begin
      // powered-down divider stops low
      n.run = 1'h0;
      n.level = 1'h0;
      n.cnt = '0;
    end else if (hold) begin
      // static preset while aligning
      n.run = 1'h0;
      n.level = initial_level_high;
      n.cnt = start_delay(initial_level_high, delay_count, low_field);
    end else if (!s.run) begin
      if (s.cnt == '0) begin
        // first rising edge, high phase of field plus one cycles
        n.run = 1'h1;
        n.level = 1'h1;
        n.cnt = {2'h0, high_field};
      end else begin
        n.cnt = s.cnt - 6'h01;
      end
    end else if (s.cnt == '0) begin
      n.level = !s.level;
      n.cnt = s.level ? {2'h0, low_field} : {2'h0, high_field};
    end else begin
      n.cnt = s.cnt - 6'h01;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign level = s.level;

endmodule

`default_nettype wire

// *** hdl/cosr_pkg.sv ***
// package: geometry, field layout, states and timing counts of the
// clock output alignment and reset block
// assumes a 100 MHz control clock for every cycle count below
`default_nettype none

package cosr_pkg;

  // channel and output geometry
  localparam int N_CHAN = 4;
  localparam int OUTS_PER_CHAN = 3;
  localparam int N_OUT = N_CHAN * OUTS_PER_CHAN;
  localparam int FIELD_W = 4; // delay, low-cycle and high-cycle fields
  localparam int DLY_W = 6; // start delay reaches 32 cycles

  // register offsets mirrored by the loose control ports
  localparam logic [11:0] REG_SERIAL_CTRL = 12'h000;
  localparam logic [11:0] REG_ALIGN_CTRL = 12'h230;
  localparam logic [11:0] REG_UPDATE = 12'h232;
  localparam logic [11:0] REG_OUT_CTRL_FIRST = 12'h0F0;
  localparam logic [11:0] REG_OUT_CTRL_LAST = 12'h0FB;
  localparam int BIT_SOFT_RST_LO = 2;
  localparam int BIT_SOFT_RST_HI = 5;
  localparam int BIT_SOFT_ALIGN = 0;
  localparam int BIT_DIST_PD = 1;
  localparam int BIT_UPDATE = 0;

  // output control field positions
  localparam int OC_PD = 0;
  localparam int OC_SWING = 1; // two bits
  localparam int OC_INV = 3;
  localparam int OC_SE_MODE = 4;
  localparam int OC_SE_A_EN = 5;
  localparam int OC_SE_B_EN = 6;
  localparam int OC_SE_A_INV = 7;
  localparam int OC_SE_B_INV = 8;
  localparam int OUT_CFG_W = 9;
  localparam logic [OUT_CFG_W-1:0] OUT_CFG_RST = 9'h000;

  // timing, figures in their own units
  localparam int CLK_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int NS_PER_MS = 1000000;
  localparam int SYNC_STAGES = 2;
  localparam int ALIGN_PIPE_CYC = 15;
  localparam int ALIGN_LOAD = ALIGN_PIPE_CYC - SYNC_STAGES - 1;
  localparam int POR_SYNC_MS = 50;
  localparam int POR_TOGGLE_MS = 70;
  localparam int HW_FAST_US = 2;
  localparam int EE_RESTORE_MS = 20;
  localparam int POR_SYNC_CYC = POR_SYNC_MS * (NS_PER_MS / CLK_NS);
  localparam int POR_TOGGLE_CYC = POR_TOGGLE_MS * (NS_PER_MS / CLK_NS);
  localparam int HW_FAST_CYC = HW_FAST_US * NS_PER_US / CLK_NS;
  localparam int EE_RESTORE_CYC = EE_RESTORE_MS * (NS_PER_MS / CLK_NS);
  localparam int TMR_W = 24;

  // reset sequencer states
  typedef enum logic [4:0] {
    RS_POR = 5'h01,
    RS_RUN = 5'h02,
    RS_HW = 5'h04,
    RS_SOFT = 5'h08,
    RS_SETTLE = 5'h10
  } cosr_rst_t;

endpackage

`default_nettype wire

// *** hdl/cosr_top.sv ***
// top of the clock output alignment, driver select and reset block
// assumes all pins arrive synchronous to MCLK except the alignment
// pin, which is resynchronised; MCLK stands in for the divider clock
`default_nettype none

// Behaviour
// - phase up to 15 delays that many cycles
// - phase 16+ delays phase-16 plus M plus one
// - excluded channel keeps clocking, never aligned
// - pin or soft bits set-then-cleared trigger alignment
// - power-up, reset pulse, sleep pulse also align
// - calibration holds alignment request until done
// - pin release to clocking about fifteen cycles
// - soft align bit acts only on update
// - held level from start-high, phase after release
// - channel settings apply to all its outputs
// - output control bits 2:1 select swing
// - per output polarity and power-down
// - distribution power-down stops all drivers together
// - safe power-down by bit, channel, sleep
// - single-ended mode enables both drivers automatically
// - bits 6:5 enable drivers, disabled ones tristate
// - power-on load, align, then toggle later
// - reset pin restores settings, aligns, waits
// - both soft reset bits restore per select
// - soft reset keeps other bits, outputs static
// - soft reset ends only on next serial tick
// - phase value is sixteen start-high plus delay
// - cycle fields hold count minus one
module cosr_top
  import cosr_pkg::*;
#(
  parameter int POR_SYNC_CYC_P = cosr_pkg::POR_SYNC_CYC,
  parameter int POR_TOGGLE_CYC_P = cosr_pkg::POR_TOGGLE_CYC,
  parameter int EE_RESTORE_CYC_P = cosr_pkg::EE_RESTORE_CYC
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic ALIGN_N,
  input wire logic HW_RESET_N,
  input wire logic CHIP_SLEEP_N,
  input wire logic EEPROM_SEL,
  input wire logic SOFT_ALIGN,
  input wire logic DIST_PD,
  input wire logic UPDATE_STROBE,
  input wire logic SOFT_RST_LO,
  input wire logic SOFT_RST_HI,
  input wire logic SCLK_TICK,
  input wire logic CAL_BUSY,
  input wire logic [cosr_pkg::N_CHAN-1:0] IGNORE_ALIGN,
  input wire logic [cosr_pkg::N_CHAN-1:0] INITIAL_LEVEL_HIGH,
  input wire logic [cosr_pkg::N_CHAN*cosr_pkg::FIELD_W-1:0] DELAY_COUNT,
  input wire logic [cosr_pkg::N_CHAN*cosr_pkg::FIELD_W-1:0] LOW_CYCLES,
  input wire logic [cosr_pkg::N_CHAN*cosr_pkg::FIELD_W-1:0] HIGH_CYCLES,
  input wire logic [cosr_pkg::N_CHAN-1:0] CHAN_PD,
  input wire logic [cosr_pkg::N_OUT*cosr_pkg::OUT_CFG_W-1:0] OUT_CFG,
  input wire logic [cosr_pkg::N_OUT-1:0] OUT_CFG_WR,
  output logic [cosr_pkg::N_OUT-1:0] DIFF_OUT,
  output logic [cosr_pkg::N_OUT-1:0] DIFF_SAFE_PD,
  output logic DIFF_TOTAL_PD,
  output logic [cosr_pkg::N_OUT*2-1:0] SWING,
  output logic [cosr_pkg::N_OUT-1:0] SE_A_OUT,
  output logic [cosr_pkg::N_OUT-1:0] SE_A_OE,
  output logic [cosr_pkg::N_OUT-1:0] SE_B_OUT,
  output logic [cosr_pkg::N_OUT-1:0] SE_B_OE,
  output logic ALIGN_ACTIVE,
  output logic RESET_ACTIVE,
  output logic LOAD_EEPROM,
  output logic LOAD_DEFAULTS,
  output logic SOFT_BITS_CLEAR
);

  import cosr_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [1:0] pin_sync; // [0] first stage, [1] second stage
    logic soft_align; // soft align bit as taken at update
    logic req_q; // alignment request one cycle ago
    logic [3:0] pipe; // release pipeline countdown
    cosr_rst_t rst; // reset sequencer state
    logic [TMR_W-1:0] tmr; // sequencer timer
    logic load_ee; // pulse: restore stored settings
    logic load_def; // pulse: restore built-in settings
    logic bits_clear; // pulse: self-clearing bits drop
    logic [N_OUT-1:0][OUT_CFG_W-1:0] cfg; // output control copies
    logic [N_OUT-1:0][1:0] se_en; // single-ended enables {b,a}
    logic [N_OUT-1:0] diff; // differential data
    logic [N_OUT-1:0] se_a; // single-ended a data
    logic [N_OUT-1:0] se_b; // single-ended b data
  } cosr_top_state_t;

  cosr_top_state_t s;
  cosr_top_state_t n;

  logic soft_req; // both soft reset bits written
  logic rst_busy; // any reset sequence in progress
  logic req; // combined alignment request
  logic hold; // request or release pipeline still running
  logic [N_CHAN-1:0] ch_level; // divider outputs
  logic [N_OUT-1:0] safe_pd; // per driver safe power-down

  // soft reset needs both bits of the serial control register
  assign soft_req = SOFT_RST_LO & SOFT_RST_HI;

  // outputs of channels not excluded from alignment stay static for the whole reset sequence
  assign rst_busy = (s.rst != RS_RUN);

  // every source of an alignment; each holds the outputs while
  // active and the falling edge of the request starts the release
  always_comb begin
    req = !s.pin_sync[1];
    req = req | s.soft_align;
    req = req | DIST_PD;
    req = req | !CHIP_SLEEP_N;
    req = req | CAL_BUSY;
    req = req | rst_busy;
  end

  // request and pipeline together keep the included dividers frozen
  assign hold = req | s.req_q | (s.pipe != 4'h0);

  // next-state logic
  always_comb begin
    n = s;
    n.load_ee = 1'h0;
    n.load_def = 1'h0;
    n.bits_clear = 1'h0;

    // alignment pin through two stages; the first is read only here
    n.pin_sync = {s.pin_sync[0], ALIGN_N};

    // soft align changes only on the update strobe, in both directions
    if (UPDATE_STROBE) begin
      n.soft_align = SOFT_ALIGN;
    end

    // release pipeline: loaded when the request falls, so the first
    // divider edge lands a fixed count after the pin rising edge
    n.req_q = req;
    if (req) begin
      n.pipe = 4'h0;
    end else if (s.req_q) begin
      n.pipe = 4'(ALIGN_LOAD);
    end else if (s.pipe != 4'h0) begin
      n.pipe = s.pipe - 4'h1;
    end

    // reset sequencer
    case (s.rst)
      RS_POR: begin
        // first cycle after release: restore from the select pin
        if (s.tmr == '0) begin
          n.load_ee = EEPROM_SEL;
          n.load_def = !EEPROM_SEL;
        end
        if (s.tmr == TMR_W'(POR_SYNC_CYC_P - 1)) begin
          // alignment point reached, outputs wait the remainder
          n.rst = RS_SETTLE;
          n.tmr = TMR_W'(POR_TOGGLE_CYC_P - POR_SYNC_CYC_P);
        end else begin
          n.tmr = s.tmr + 24'h00_0001;
        end
      end
      RS_RUN: begin
        if (soft_req) begin
          // restore on entry, then wait for the serial tick
          n.rst = RS_SOFT;
          n.load_ee = EEPROM_SEL;
          n.load_def = !EEPROM_SEL;
        end
      end
      RS_HW: begin
        if (HW_RESET_N) begin
          // pin released: restore, then wait before toggling
          n.rst = RS_SETTLE;
          n.load_ee = EEPROM_SEL;
          n.load_def = !EEPROM_SEL;
          if (EEPROM_SEL) begin
            n.tmr = TMR_W'(EE_RESTORE_CYC_P);
          end else begin
            n.tmr = TMR_W'(HW_FAST_CYC);
          end
        end
      end
      RS_SOFT: begin
        // held in reset until one more serial clock arrives
        if (SCLK_TICK) begin
          n.bits_clear = 1'h1;
          n.rst = RS_SETTLE;
          if (EEPROM_SEL) begin
            n.tmr = TMR_W'(EE_RESTORE_CYC_P);
          end else begin
            n.tmr = TMR_W'(HW_FAST_CYC);
          end
        end
      end
      RS_SETTLE: begin
        if (s.tmr == '0) begin
          n.rst = RS_RUN;
        end else begin
          n.tmr = s.tmr - 24'h00_0001;
        end
      end
      default: begin
        // illegal code: restart as from power-on
        n.rst = RS_POR;
        n.tmr = '0;
      end
    endcase

    // a low reset pin wins over every sequence step
    if (!HW_RESET_N) begin
      n.rst = RS_HW;
      n.tmr = '0;
      n.load_ee = 1'h0;
      n.load_def = 1'h0;
    end

    // output control writes; entering single-ended mode turns both
    // single-ended drivers on, later writes set them one by one
    for (int i = 0; i < N_OUT; i++) begin
      if (OUT_CFG_WR[i]) begin
        n.cfg[i] = OUT_CFG[i*OUT_CFG_W +: OUT_CFG_W];
        if (OUT_CFG[i*OUT_CFG_W+OC_SE_MODE] && !s.cfg[i][OC_SE_MODE]) begin
          n.se_en[i] = 2'h3;
        end else begin
          n.se_en[i] = {OUT_CFG[i*OUT_CFG_W+OC_SE_B_EN],
                        OUT_CFG[i*OUT_CFG_W+OC_SE_A_EN]};
        end
      end
    end

    // driver data: outputs follow their channel's divider; differential data is held low in safe or total power-down or single-ended mode
    for (int i = 0; i < N_OUT; i++) begin
      if (safe_pd[i] || DIST_PD || s.cfg[i][OC_SE_MODE]) begin
        n.diff[i] = 1'h0;
      end else begin
        n.diff[i] = ch_level[i/OUTS_PER_CHAN] ^ s.cfg[i][OC_INV];
      end
      n.se_a[i] = ch_level[i/OUTS_PER_CHAN] ^ s.cfg[i][OC_SE_A_INV];
      n.se_b[i] = ch_level[i/OUTS_PER_CHAN] ^ s.cfg[i][OC_SE_B_INV];
    end
  end

  // state register; reset takes constants only
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      s <= '0;
      s.rst <= RS_POR;
      s.pin_sync <= 2'h3;
      for (int i = 0; i < N_OUT; i++) begin
        s.cfg[i] <= OUT_CFG_RST;
      end
    end else begin
      s <= n;
    end
  end

  // channel dividers; an excluded channel ignores the hold and keeps
  // running, so it is neither static nor aligned to the others
  for (genvar c = 0; c < N_CHAN; c++) begin : g_chan
    cosr_chdiv u_div (
      .clk(MCLK),
      .rst_n(NRST),
      .hold(hold & !IGNORE_ALIGN[c]),
      .pd(CHAN_PD[c] | !CHIP_SLEEP_N | DIST_PD),
      .initial_level_high(INITIAL_LEVEL_HIGH[c]),
      .delay_count(DELAY_COUNT[c*FIELD_W +: FIELD_W]),
      .low_field(LOW_CYCLES[c*FIELD_W +: FIELD_W]),
      .high_field(HIGH_CYCLES[c*FIELD_W +: FIELD_W]),
      .level(ch_level[c])
    );
  end

  // per output power-down, swing and single-ended enables
  for (genvar i = 0; i < N_OUT; i++) begin : g_out
    // own bit, its channel, or sleep put the driver in safe mode
    assign safe_pd[i] = s.cfg[i][OC_PD] | CHAN_PD[i/OUTS_PER_CHAN] | !CHIP_SLEEP_N;
    assign SWING[2*i +: 2] = s.cfg[i][OC_SWING +: 2];
    // a disabled or powered-down single-ended driver is tristated
    assign SE_A_OE[i] = s.cfg[i][OC_SE_MODE] & s.se_en[i][0] & !safe_pd[i];
    assign SE_B_OE[i] = s.cfg[i][OC_SE_MODE] & s.se_en[i][1] & !safe_pd[i];
  end

  // flip-flop outputs
  assign DIFF_OUT = s.diff;
  assign SE_A_OUT = s.se_a;
  assign SE_B_OUT = s.se_b;
  assign LOAD_EEPROM = s.load_ee;
  assign LOAD_DEFAULTS = s.load_def;
  assign SOFT_BITS_CLEAR = s.bits_clear;

  // status and power-down levels
  assign DIFF_SAFE_PD = safe_pd;
  assign DIFF_TOTAL_PD = DIST_PD;
  assign ALIGN_ACTIVE = hold;
  assign RESET_ACTIVE = rst_busy;

endmodule

`default_nettype wire

// *** test/cosr_chk.sv ***
// checker: port-level timing and level relations of the alignment block
// assumes one MCLK domain with NRST as its asynchronous reset
`default_nettype none
module cosr_chk (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic ALIGN_N,
  input wire logic HW_RESET_N,
  input wire logic CHIP_SLEEP_N,
  input wire logic EEPROM_SEL,
  input wire logic DIST_PD,
  input wire logic SCLK_TICK,
  input wire logic CAL_BUSY,
  input wire logic [cosr_pkg::N_CHAN-1:0] IGNORE_ALIGN,
  input wire logic [cosr_pkg::N_CHAN-1:0] CHAN_PD,
  input wire logic [cosr_pkg::N_OUT*cosr_pkg::OUT_CFG_W-1:0] OUT_CFG,
  input wire logic [cosr_pkg::N_OUT-1:0] OUT_CFG_WR,
  input wire logic [cosr_pkg::N_OUT-1:0] DIFF_OUT,
  input wire logic [cosr_pkg::N_OUT-1:0] DIFF_SAFE_PD,
  input wire logic DIFF_TOTAL_PD,
  input wire logic [cosr_pkg::N_OUT*2-1:0] SWING,
  input wire logic ALIGN_ACTIVE,
  input wire logic RESET_ACTIVE,
  input wire logic LOAD_EEPROM,
  input wire logic LOAD_DEFAULTS,
  input wire logic SOFT_BITS_CLEAR
);
  timeunit 1ns;
  timeprecision 100ps;
  import cosr_pkg::*;
  // single domain, so clock and reset are given once
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // channel 0 held with nothing else able to move its output
  sequence s_frozen;
    (ALIGN_ACTIVE && !RESET_ACTIVE && CHIP_SLEEP_N && !DIST_PD && !CHAN_PD[0]
      && !IGNORE_ALIGN[0] && !OUT_CFG_WR[0]) [*4];
  endsequence
  // pin release with no reset or calibration pending
  sequence s_pin_up;
    $rose(ALIGN_N) && !RESET_ACTIVE && !CAL_BUSY;
  endsequence
  a_total_pd: assert property (DIFF_TOTAL_PD == DIST_PD)
    else $error("total power-down differs from its control");
  a_sleep_safe: assert property (!CHIP_SLEEP_N |-> &DIFF_SAFE_PD)
    else $error("sleep left a driver out of safe power-down");
  a_chan_safe: assert property (CHAN_PD[0] |-> &DIFF_SAFE_PD[2:0])
    else $error("channel power-down left a driver on");
  a_swing_write: assert property (OUT_CFG_WR[0] |=> SWING[1:0] == $past(OUT_CFG[2:1]))
    else $error("swing does not follow the written field");
  a_pin_reset: assert property (!HW_RESET_N |=> RESET_ACTIVE)
    else $error("reset pin low without reset active");
  a_load_select: assert property ((LOAD_EEPROM || LOAD_DEFAULTS) |->
    (LOAD_EEPROM == EEPROM_SEL) && (LOAD_EEPROM != LOAD_DEFAULTS))
    else $error("settings source does not match the select pin");
  a_clear_tick: assert property (SOFT_BITS_CLEAR |-> $past(SCLK_TICK))
    else $error("soft bits cleared without a serial tick");
  a_cal_hold: assert property (CAL_BUSY [*3] |-> ALIGN_ACTIVE)
    else $error("calibration running without alignment hold");
  a_static_hold: assert property (s_frozen |-> $stable(DIFF_OUT[0]))
    else $error("held output moved during alignment");
  a_pin_pipe: assert property (s_pin_up |-> ALIGN_ACTIVE [*8] ##[4:10] !ALIGN_ACTIVE)
    else $error("pin release to clocking out of range");
endmodule

bind cosr_top cosr_chk u_chk (.MCLK(MCLK), .NRST(NRST), .ALIGN_N(ALIGN_N),
  .HW_RESET_N(HW_RESET_N), .CHIP_SLEEP_N(CHIP_SLEEP_N), .EEPROM_SEL(EEPROM_SEL),
  .DIST_PD(DIST_PD), .SCLK_TICK(SCLK_TICK), .CAL_BUSY(CAL_BUSY),
  .IGNORE_ALIGN(IGNORE_ALIGN), .CHAN_PD(CHAN_PD), .OUT_CFG(OUT_CFG), .OUT_CFG_WR(OUT_CFG_WR),
  .DIFF_OUT(DIFF_OUT), .DIFF_SAFE_PD(DIFF_SAFE_PD), .DIFF_TOTAL_PD(DIFF_TOTAL_PD),
  .SWING(SWING), .ALIGN_ACTIVE(ALIGN_ACTIVE), .RESET_ACTIVE(RESET_ACTIVE),
  .LOAD_EEPROM(LOAD_EEPROM), .LOAD_DEFAULTS(LOAD_DEFAULTS), .SOFT_BITS_CLEAR(SOFT_BITS_CLEAR));
`default_nettype wire

// *** test/cosr_host.sv ***
// host model: alignment pin, reset pin and serial control bits
// assumes the testbench calls its tasks; all changes land on falling MCLK
`default_nettype none
module cosr_host (
  input wire logic mclk,
  output logic align_n,
  output logic hw_reset_n,
  output logic soft_align,
  output logic update_strobe,
  output logic soft_rst_lo,
  output logic soft_rst_hi,
  output logic sclk_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle at time zero: pins released, bits clear
  initial begin
    align_n = 1'b1;
    hw_reset_n = 1'b1;
    soft_align = 1'b0;
    update_strobe = 1'b0;
    soft_rst_lo = 1'b0;
    soft_rst_hi = 1'b0;
    sclk_tick = 1'b0;
  end
  // alignment pin level, low requests and high releases
  task automatic pin_set(input logic v);
    @(negedge mclk) align_n = v;
  endtask
  // soft align bit; a real host always strobes, s=0 leaves it pending
  task automatic soft_bit(input logic v, input logic s);
    @(negedge mclk) soft_align = v;
    @(negedge mclk) update_strobe = s;
    @(negedge mclk) update_strobe = 1'b0;
  endtask
  // reset pin pulse of n cycles
  task automatic hw_pulse(input int n);
    @(negedge mclk) hw_reset_n = 1'b0;
    repeat (n) @(negedge mclk);
    hw_reset_n = 1'b1;
  endtask
  // both soft reset bits written together
  task automatic soft_rst();
    @(negedge mclk) soft_rst_lo = 1'b1;
    soft_rst_hi = 1'b1;
  endtask
  // the further serial clock, then the bits dropped by the host
  task automatic tick_drop();
    @(negedge mclk) sclk_tick = 1'b1;
    @(negedge mclk) sclk_tick = 1'b0;
    repeat (2) @(negedge mclk);
    soft_rst_lo = 1'b0;
    soft_rst_hi = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/cosr_top_tb.sv ***
// testbench: directed scenarios for alignment, drivers and reset sequencing
// assumes short sequencer counts; inputs change on falling MCLK
`default_nettype none
module cosr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cosr_pkg::*;
  localparam int EE_P = 30;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic sleep_n = 1'b1;
  logic ee_sel = 1'b0;
  logic dist_pd = 1'b0;
  logic cal_busy = 1'b0;
  logic [N_CHAN-1:0] ign = '0;
  logic [N_CHAN-1:0] lvl = 4'h4; // only channel 2 starts high
  logic [N_CHAN*FIELD_W-1:0] dly = 16'hf250; // delays 0,5,2,15 on channels 0..3
  logic [N_CHAN*FIELD_W-1:0] lowc = 16'hf3ff; // channel 2 low count 4, others 16
  logic [N_CHAN*FIELD_W-1:0] highc = 16'hffff; // every high phase 16 cycles
  logic [N_CHAN-1:0] chan_pd = '0;
  logic [N_OUT*OUT_CFG_W-1:0] cfg = '0;
  logic [N_OUT-1:0] cfg_wr = '0;
  logic [N_OUT-1:0] dout, spd, aout, aoe, bout, boe;
  logic [N_OUT*2-1:0] swing;
  logic tpd, al_act, rs_act, ld_ee, ld_def, clr;
  logic align_n, hrst_n, s_al, upd, srl, srh, tick;
  int num_errors = 0;
  int checks = 0;
  int n_ee = 0;
  int n_def = 0;
  int n_clr = 0;
  always #5 mclk = ~mclk;
  cosr_host host (.mclk(mclk), .align_n(align_n), .hw_reset_n(hrst_n), .soft_align(s_al),
    .update_strobe(upd), .soft_rst_lo(srl), .soft_rst_hi(srh), .sclk_tick(tick));
  // sequencer counts kept short so every reset path fits the run
  cosr_top #(.POR_SYNC_CYC_P(20), .POR_TOGGLE_CYC_P(40), .EE_RESTORE_CYC_P(EE_P)) uut (
    .MCLK(mclk), .NRST(nrst), .ALIGN_N(align_n), .HW_RESET_N(hrst_n),
    .CHIP_SLEEP_N(sleep_n), .EEPROM_SEL(ee_sel), .SOFT_ALIGN(s_al), .DIST_PD(dist_pd),
    .UPDATE_STROBE(upd), .SOFT_RST_LO(srl), .SOFT_RST_HI(srh), .SCLK_TICK(tick),
    .CAL_BUSY(cal_busy), .IGNORE_ALIGN(ign), .INITIAL_LEVEL_HIGH(lvl),
    .DELAY_COUNT(dly), .LOW_CYCLES(lowc), .HIGH_CYCLES(highc),
    .CHAN_PD(chan_pd), .OUT_CFG(cfg), .OUT_CFG_WR(cfg_wr), .DIFF_OUT(dout),
    .DIFF_SAFE_PD(spd), .DIFF_TOTAL_PD(tpd), .SWING(swing), .SE_A_OUT(aout), .SE_A_OE(aoe),
    .SE_B_OUT(bout), .SE_B_OE(boe), .ALIGN_ACTIVE(al_act), .RESET_ACTIVE(rs_act),
    .LOAD_EEPROM(ld_ee), .LOAD_DEFAULTS(ld_def), .SOFT_BITS_CLEAR(clr));
  // count sequencer pulses away from the launching edge, so a one-cycle
  // pulse is seen at exactly one falling edge with no race
  always @(negedge mclk) begin
    n_ee <= n_ee + (ld_ee === 1'b1);
    n_def <= n_def + (ld_def === 1'b1);
    n_clr <= n_clr + (clr === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // bounded wait for reset (r=1) or alignment hold (r=0) to end
  task automatic idle(input bit r, output int n);
    n = 0;
    while (((r ? rs_act : al_act) !== 1'b0) && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400) begin
      chk(1'b0, 1'b1);
      end_sim();
    end
  endtask
  // per-output config write; the extra edge lets registered effects land
  task automatic wcfg(input int i, input logic [OUT_CFG_W-1:0] v);
    @(negedge mclk);
    cfg[OUT_CFG_W*i +: OUT_CFG_W] = v;
    cfg_wr[i] = 1'b1;
    wt(1);
    cfg_wr[i] = 1'b0;
    wt(1);
  endtask
  // expected start delay of a channel: phase value up to 15 counts itself,
  // with start-high it is delay plus low count (field plus one) plus one
  function automatic int dly_exp(input int c);
    dly_exp = lvl[c] ? dly[4*c +: 4] + lowc[4*c +: 4] + 2 : dly[4*c +: 4];
  endfunction
  // pin hold levels, then first falling edges after release per channel
  task automatic t_phase();
    int r0;
    int f[N_CHAN];
    logic [N_OUT-1:0] p;
    r0 = -1;
    foreach (f[c]) f[c] = -1;
    host.pin_set(1'b0);
    wt(18);
    for (int c = 0; c < N_CHAN; c++) chk(dout[3*c +: 3], {3{lvl[c]}});
    host.pin_set(1'b1);
    p = dout;
    for (int t = 0; t < 120; t++) begin
      @(negedge mclk);
      if (!p[0] && dout[0] && r0 < 0) r0 = t;
      for (int c = 0; c < N_CHAN; c++) if (p[3*c] && !dout[3*c] && f[c] < 0) f[c] = t;
      p = dout;
    end
    chk(f[0] - r0, highc[3:0] + 1);
    chk(f[1] - f[0], dly_exp(1) - dly_exp(0));
    chk(f[2] - f[0], dly_exp(2) - dly_exp(0));
    chk(f[3] - f[0], dly_exp(3) - dly_exp(0));
    $display("phase test done");
  endtask
  // excluded channel 3 keeps toggling while channel 0 is held
  task automatic t_excl();
    int g0;
    int g3;
    logic [N_OUT-1:0] p;
    g0 = 0;
    g3 = 0;
    ign = 4'h8;
    host.pin_set(1'b0);
    wt(6);
    p = dout;
    repeat (36) begin
      @(negedge mclk);
      g0 += (dout[0] !== p[0]);
      g3 += (dout[9] !== p[9]);
      p = dout;
    end
    host.pin_set(1'b1);
    chk(g0, 0);
    chk(g3 != 0, 1);
    idle(1'b0, g0);
    ign = 4'h0;
    $display("exclusion test done");
  endtask
  // soft align acts only with the update strobe, both on set and clear
  task automatic t_soft_align();
    int n;
    host.soft_bit(1'b1, 1'b0);
    wt(4);
    chk(al_act, 1'b0);
    host.soft_bit(1'b1, 1'b1);
    wt(4);
    chk(al_act, 1'b1);
    host.soft_bit(1'b0, 1'b0);
    wt(20);
    chk(al_act, 1'b1);
    host.soft_bit(1'b0, 1'b1);
    idle(1'b0, n);
    chk(n <= 20, 1);
    $display("soft align test done");
  endtask
  // soft reset stays active, outputs static, until the extra serial tick
  task automatic t_soft_rst();
    int e0;
    logic [N_OUT-1:0] d;
    wt(1);
    ee_sel = 1'b1;
    e0 = n_ee;
    host.soft_rst();
    wt(10);
    d = dout;
    wt(40);
    chk(rs_act, 1'b1);
    chk(dout, d);
    chk(n_ee - e0, 1);
    host.tick_drop();
    chk(n_clr, 1);
    idle(1'b1, e0);
    idle(1'b0, e0);
    $display("soft reset test done");
  endtask
  // reset pin with and without stored settings; restore time differs
  task automatic t_hw();
    int n;
    int e0;
    int d0;
    for (int s = 0; s < 2; s++) begin
      wt(1);
      ee_sel = s[0];
      e0 = n_ee;
      d0 = n_def;
      host.hw_pulse(3);
      idle(1'b1, n);
      chk(n >= (s ? EE_P : HW_FAST_CYC) && n <= (s ? EE_P : HW_FAST_CYC) + 4, 1);
      chk(s ? n_ee - e0 : n_def - d0, 1);
      idle(1'b0, n);
    end
    $display("reset pin test done");
  endtask
  // power-down paths, calibration hold and per-output driver settings
  task automatic t_pd();
    int n;
    wt(1);
    dist_pd = 1'b1;
    wt(3);
    chk(tpd, 1'b1);
    chk(al_act, 1'b1);
    dist_pd = 1'b0;
    idle(1'b0, n);
    cal_busy = 1'b1;
    wt(4);
    chk(al_act, 1'b1);
    cal_busy = 1'b0;
    idle(1'b0, n);
    chan_pd = 4'h2;
    wt(2);
    chk(spd, 12'h038);
    chan_pd = 4'h0;
    sleep_n = 1'b0;
    wt(2);
    chk(spd, 12'hfff);
    sleep_n = 1'b1;
    idle(1'b0, n);
    wcfg(0, 9'h001);
    chk(spd[0], 1'b1);
    wcfg(0, 9'h004);
    chk(swing[1:0], 2'h2);
    wcfg(1, 9'h008);
    wt(1);
    chk(dout[1] ^ dout[0], 1'b1);
    wcfg(2, 9'h010);
    chk({boe[2], aoe[2]}, 2'h3);
    wcfg(2, 9'h130);
    chk({boe[2], aoe[2]}, 2'h1);
    chk({aout[2], bout[2]}, {dout[0], !dout[0]});
    $display("driver test done");
  endtask
  // hang guard
  initial begin
    repeat (30000) @(posedge mclk);
    chk(1'b0, 1'b1);
    end_sim();
  end
  // main sequence: reset, power-on checks, then each scenario
  initial begin
    int n;
    wt(12);
    nrst = 1'b1;
    idle(1'b1, n);
    chk(n_def, 1);
    chk(n_ee, 0);
    idle(1'b0, n);
    t_phase();
    // second pass: new delay on channel 1, channel 3 now starts high
    dly[7:4] = 4'h9;
    lvl[3] = 1'b1;
    t_phase();
    t_excl();
    t_soft_align();
    t_soft_rst();
    t_hw();
    t_pd();
    end_sim();
  end
endmodule
`default_nettype wire
